// [dpcmd_defines.svh]
// constants for the two-wire digital potentiometer command interpreter
// assumes inclusion by bare name from the core module and the bench
`ifndef DPCMD_DEFINES_SVH
`define DPCMD_DEFINES_SVH
`define DPCMD_OP_RD_WIPER 4'h9
`define DPCMD_OP_WR_WIPER 4'hA
`define DPCMD_OP_RD_STORE 4'hB
`define DPCMD_OP_WR_STORE 4'hC
`define DPCMD_OP_XFR_TO_WIPER 4'hD
`define DPCMD_OP_XFR_TO_STORE 4'hE
`define DPCMD_OP_STEP 4'h2
`define DPCMD_ADDR_BIT_ONE 1'h0
`define DPCMD_TAP_MAX 6'h3F
`define DPCMD_STORE_RST 6'h20
`define DPCMD_CLK_MHZ 125
`define DPCMD_NV_WRITE_MS 10
`define DPCMD_NV_WRITE_CYC (`DPCMD_NV_WRITE_MS * 1000 * `DPCMD_CLK_MHZ)
`endif

// [dpcmd_pkg.sv]
// types shared by the potentiometer command interpreter
// assumes dpcmd_defines.svh holds all numeric constants
package dpcmd_pkg;
    typedef enum logic [2:0] {
        DPCMD_IDLE = 3'b000,
        DPCMD_ADDR = 3'b001,
        DPCMD_INSTR = 3'b011,
        DPCMD_DATA = 3'b010,
        DPCMD_SEND = 3'b110,
        DPCMD_STEP = 3'b111,
        DPCMD_SKIP = 3'b101
    } dpcmd_state_e;
    typedef struct packed {
        logic scl;
        logic sda;
    } dpcmd_bus_s;
    typedef struct packed {
        logic [3:0] opcode;
        logic [1:0] sel;
    } dpcmd_instr_s;
endpackage

// [dpcmd_sync.sv]
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; output is a clean level in ref_clk_in domain
`timescale 1ns/1ps
module dpcmd_sync #(
    parameter int WIDTH = 2
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] lvl_q;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge ref_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    s1_q[i] <= 1'b1;
                    s2_q[i] <= 1'b1;
                    s3_q[i] <= 1'b1;
                    lvl_q[i] <= 1'b1;
                end else begin
                    s1_q[i] <= pin_in[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    // a change counts once the two later stages agree
                    if (s2_q[i] == s3_q[i]) begin
                        lvl_q[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate
    assign level_out = lvl_q;
endmodule // dpcmd_sync

// [dpcmd_core.sv]
// two-wire command interpreter of a 64-tap digital potentiometer
// assumes scl/sda pins sampled by ref_clk_in, well above the bus rate
// Functional notes
// RULE_01 - read wiper returns two zeros, six bits
// RULE_02 - write wiper takes data byte, acks each
// RULE_03 - read store returns selected six-bit value
// RULE_04 - write store, stop starts nonvolatile write
// RULE_05 - copy store into wiper, no data byte
// RULE_06 - save wiper into store on stop
// RULE_07 - step mode: unacked step bits until stop
// RULE_08 - step up if sda high, else down
// RULE_09 - nonvolatile write finishes within ten ms
// RULE_10 - reset loads store zero into wiper
// RULE_11 - six-bit wiper decodes to one-hot taps
// RULE_12 - address mismatch: no acknowledge, frame ignored
`timescale 1ns/1ps
`include "dpcmd_defines.svh"
module dpcmd_core #(
    parameter int NV_WRITE_CYC = `DPCMD_NV_WRITE_CYC,
    // device type identifier; the default value is arbitrary
    parameter logic [3:0] TYPE_ID = 4'h6
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic addr_strap_high_in,
    input wire logic addr_strap_mid_in,
    input wire logic addr_strap_low_in,
    output logic [5:0] wiper_position_out,
    output logic [63:0] tap_select_out,
    output logic nv_busy_out
);
    dpcmd_pkg::dpcmd_bus_s bus;
    dpcmd_pkg::dpcmd_bus_s bus_prev_q;
    dpcmd_pkg::dpcmd_state_e state_q;
    dpcmd_pkg::dpcmd_instr_s instr_q;
    // straps ride the same synchroniser as the bus pins
    logic [4:0] pins_lvl;
    logic op_rd_q;
    logic op_data_q;
    logic [7:0] shift_q;
    logic [3:0] bitcnt_q;
    logic ack_phase_q;
    logic ack_drive_q;
    logic [5:0] wiper_position_reg_q;
    logic [5:0] nonvolatile_store_reg_q [4];
    logic nv_pend_q;
    logic [1:0] nv_sel_q;
    logic [5:0] nv_data_q;
    logic [31:0] nv_cnt_q;
    logic [7:0] tx_q;

    dpcmd_sync #(.WIDTH(5)) i_dpcmd_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .pin_in({addr_strap_high_in, addr_strap_mid_in, addr_strap_low_in,
                 scl_in, sda_in}),
        .level_out(pins_lvl)
    );
    assign bus.scl = pins_lvl[1];
    assign bus.sda = pins_lvl[0];

    wire scl_rise = bus.scl & ~bus_prev_q.scl;
    wire scl_fall = ~bus.scl & bus_prev_q.scl;
    wire start_det = bus.scl & bus_prev_q.scl & bus_prev_q.sda & ~bus.sda;
    wire stop_det = bus.scl & bus_prev_q.scl & ~bus_prev_q.sda & bus.sda;
    wire [7:0] byte_in = {shift_q[6:0], bus.sda};
    wire byte_done = scl_rise & (bitcnt_q == 4'd7) & ~ack_phase_q;
    wire addr_match = (byte_in[7:4] == TYPE_ID)
        & (byte_in[3] == pins_lvl[4])
        & (byte_in[2] == pins_lvl[3])
        & (byte_in[1] == `DPCMD_ADDR_BIT_ONE)
        & (byte_in[0] == pins_lvl[2]); // RULE_12
    wire [3:0] op = byte_in[7:4];
    wire op_rd = (op == `DPCMD_OP_RD_WIPER) | (op == `DPCMD_OP_RD_STORE);
    wire op_data = (op == `DPCMD_OP_WR_WIPER) | (op == `DPCMD_OP_WR_STORE);
    wire op_valid = op_rd | op_data | (op == `DPCMD_OP_XFR_TO_WIPER)
        | (op == `DPCMD_OP_XFR_TO_STORE) | (op == `DPCMD_OP_STEP);
    wire [5:0] rd_val = (op == `DPCMD_OP_RD_WIPER) ? wiper_position_reg_q
        : nonvolatile_store_reg_q[byte_in[3:2]]; // RULE_01 RULE_03
    wire step_up = wiper_position_reg_q != `DPCMD_TAP_MAX;
    wire step_dn = wiper_position_reg_q != 6'h00;
    wire nv_done = nv_pend_q & (nv_cnt_q == 32'(NV_WRITE_CYC - 1));

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_prev_q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            bus_prev_q <= bus;
        end
    end

    // bus framing: bit counter, acknowledge slot and state
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= dpcmd_pkg::DPCMD_IDLE;
            instr_q <= '0;
            shift_q <= 8'h00;
            bitcnt_q <= 4'd0;
            ack_phase_q <= 1'b0;
            ack_drive_q <= 1'b0;
            tx_q <= 8'h00;
        end else if (start_det) begin
            state_q <= dpcmd_pkg::DPCMD_ADDR;
            bitcnt_q <= 4'd0;
            ack_phase_q <= 1'b0;
            ack_drive_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= dpcmd_pkg::DPCMD_IDLE;
            ack_drive_q <= 1'b0;
        end else begin
            case (state_q)
                dpcmd_pkg::DPCMD_ADDR, dpcmd_pkg::DPCMD_INSTR,
                dpcmd_pkg::DPCMD_DATA: begin
                    if (scl_rise & ~ack_phase_q) begin
                        shift_q <= byte_in;
                        bitcnt_q <= bitcnt_q + 4'd1;
                    end
                    if (byte_done) begin
                        ack_phase_q <= 1'b1;
                    end
                    if (scl_fall & ack_phase_q & bitcnt_q == 4'd8) begin
                        // entering acknowledge slot
                        ack_drive_q <= 1'b1;
                        bitcnt_q <= 4'd9;
                    end else if (scl_fall & bitcnt_q == 4'd9) begin
                        ack_drive_q <= 1'b0;
                        ack_phase_q <= 1'b0;
                        bitcnt_q <= 4'd0;
                        case (state_q)
                            dpcmd_pkg::DPCMD_INSTR: begin
                                if (instr_q.opcode == `DPCMD_OP_STEP) begin
                                    state_q <= dpcmd_pkg::DPCMD_STEP; // RULE_07
                                end else if (op_rd_q) begin
                                    state_q <= dpcmd_pkg::DPCMD_SEND;
                                end else if (op_data_q) begin
                                    state_q <= dpcmd_pkg::DPCMD_DATA;
                                end else begin
                                    state_q <= dpcmd_pkg::DPCMD_SKIP;
                                end
                            end
                            dpcmd_pkg::DPCMD_ADDR: begin
                                state_q <= dpcmd_pkg::DPCMD_INSTR;
                            end
                            default: begin
                                state_q <= dpcmd_pkg::DPCMD_SKIP;
                            end
                        endcase
                    end
                    if (byte_done) begin
                        if (state_q == dpcmd_pkg::DPCMD_ADDR & ~addr_match) begin
                            state_q <= dpcmd_pkg::DPCMD_SKIP; // RULE_12
                            ack_phase_q <= 1'b0;
                        end else if (state_q == dpcmd_pkg::DPCMD_INSTR) begin
                            if (op_valid) begin
                                instr_q <= '{opcode: op, sel: byte_in[3:2]};
                                tx_q <= {2'b00, rd_val};
                            end else begin
                                state_q <= dpcmd_pkg::DPCMD_SKIP;
                                ack_phase_q <= 1'b0;
                            end
                        end
                    end
                end
                dpcmd_pkg::DPCMD_SEND: begin
                    // shift out on falling edge; master ack ignored
                    if (scl_fall) begin
                        if (bitcnt_q == 4'd8) begin
                            state_q <= dpcmd_pkg::DPCMD_SKIP;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            bitcnt_q <= bitcnt_q + 4'd1;
                        end
                    end
                end
                dpcmd_pkg::DPCMD_IDLE, dpcmd_pkg::DPCMD_STEP,
                dpcmd_pkg::DPCMD_SKIP: begin
                    ack_drive_q <= 1'b0;
                end
                default: begin
                    state_q <= dpcmd_pkg::DPCMD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            op_rd_q <= 1'b0;
            op_data_q <= 1'b0;
        end else if (byte_done & state_q == dpcmd_pkg::DPCMD_INSTR) begin
            op_rd_q <= op_rd;
            op_data_q <= op_data;
        end
    end

    wire wr_wiper = byte_done & (state_q == dpcmd_pkg::DPCMD_DATA)
        & (instr_q.opcode == `DPCMD_OP_WR_WIPER); // RULE_02
    wire wr_store = byte_done & (state_q == dpcmd_pkg::DPCMD_DATA)
        & (instr_q.opcode == `DPCMD_OP_WR_STORE);
    wire xfr_wiper = byte_done & (state_q == dpcmd_pkg::DPCMD_INSTR)
        & (op == `DPCMD_OP_XFR_TO_WIPER); // RULE_05
    wire step_ev = scl_rise & (state_q == dpcmd_pkg::DPCMD_STEP);
    // an nv write is armed by its frame and launched only by the stop
    logic arm_q;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            arm_q <= 1'b0;
            nv_sel_q <= 2'd0;
            nv_data_q <= 6'h00;
        end else if (start_det) begin
            arm_q <= 1'b0;
        end else if (wr_store) begin
            arm_q <= 1'b1; // RULE_04
            nv_sel_q <= instr_q.sel;
            nv_data_q <= byte_in[5:0];
        end else if (byte_done & state_q == dpcmd_pkg::DPCMD_INSTR
            & op == `DPCMD_OP_XFR_TO_STORE) begin
            arm_q <= 1'b1; // RULE_06
            nv_sel_q <= byte_in[3:2];
            nv_data_q <= wiper_position_reg_q;
        end else if (stop_det) begin
            arm_q <= 1'b0;
        end
    end

    // storage is initialised at reset; a real part keeps it across power
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            nv_pend_q <= 1'b0;
            nv_cnt_q <= 32'd0;
            for (int k = 0; k < 4; k++) begin
                nonvolatile_store_reg_q[k] <= `DPCMD_STORE_RST;
            end
        end else if (stop_det & arm_q & ~nv_pend_q) begin
            nv_pend_q <= 1'b1;
            nv_cnt_q <= 32'd0;
        end else if (nv_done) begin
            nv_pend_q <= 1'b0; // RULE_09
            nonvolatile_store_reg_q[nv_sel_q] <= nv_data_q;
        end else if (nv_pend_q) begin
            nv_cnt_q <= nv_cnt_q + 32'd1;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wiper_position_reg_q <= `DPCMD_STORE_RST; // RULE_10
        end else if (wr_wiper) begin
            wiper_position_reg_q <= byte_in[5:0];
        end else if (xfr_wiper) begin
            wiper_position_reg_q <= nonvolatile_store_reg_q[byte_in[3:2]];
        end else if (step_ev & bus.sda & step_up) begin
            wiper_position_reg_q <= wiper_position_reg_q + 6'd1; // RULE_08
        end else if (step_ev & ~bus.sda & step_dn) begin
            wiper_position_reg_q <= wiper_position_reg_q - 6'd1; // RULE_08
        end
    end

    genvar t;
    generate
        for (t = 0; t < 64; t++) begin : g_tap
            assign tap_select_out[t] = wiper_position_reg_q == 6'(t); // RULE_11
        end
    endgenerate

    wire send_zero = (state_q == dpcmd_pkg::DPCMD_SEND) & (bitcnt_q != 4'd8)
        & ~tx_q[7];
    assign sda_out = 1'b0;
    assign sda_oe_out = ack_drive_q | send_zero;
    assign wiper_position_out = wiper_position_reg_q;
    assign nv_busy_out = nv_pend_q;
endmodule // dpcmd_core

// [dpcmd_core_props.sv]
// assertions on the pins of the potentiometer command interpreter
// assumes a bind to dpcmd_core; pin sync lag stays under eight clocks
`timescale 1ns/1ps
module dpcmd_core_chk #(
    parameter int NV_WRITE_CYC = 20
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic [5:0] wiper_position_out,
    input wire logic [63:0] tap_select_out,
    input wire logic nv_busy_out
);
    int busy_cnt_q;
    logic [7:0] since_stop_q;
    logic sda_prev_q;
    // stop seen on raw pins, ahead of the synchronised view
    wire stop_seen = scl_in && sda_in && !sda_prev_q;
    wire [7:0] stop_age = since_stop_q + {7'h0, ~&since_stop_q};
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_cnt_q <= 0;
            since_stop_q <= 8'hFF;
            sda_prev_q <= 1'b1;
        end else begin
            busy_cnt_q <= nv_busy_out ? busy_cnt_q + 1 : 0;
            since_stop_q <= stop_seen ? 8'h00 : stop_age;
            sda_prev_q <= sda_in;
        end
    end
    tap_onehot_a: assert property (
        tap_select_out == (64'h1 << wiper_position_out))
        else $error("tap select does not match the wiper");
    reset_load_a: assert property (
        $fell(rst_in) |-> wiper_position_out == 6'h20 && !sda_oe_out)
        else $error("wiper not loaded from store zero");
    open_drain_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    ack_edge_a: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("data pin changed while clock high");
    ack_hold_a: assert property (
        $rose(sda_oe_out) |-> sda_oe_out [*8])
        else $error("data pin pulled low too briefly");
    busy_min_a: assert property (
        $rose(nv_busy_out) |-> nv_busy_out [*8])
        else $error("store write too short");
    busy_cause_a: assert property (
        $rose(nv_busy_out) |-> since_stop_q <= 8'h08)
        else $error("store write began without a stop");
    busy_max_a: assert property (
        nv_busy_out |-> busy_cnt_q <= NV_WRITE_CYC + 2)
        else $error("store write took too long");
    cover property ($rose(nv_busy_out));
    cover property ($rose(sda_oe_out));
    cover property (wiper_position_out == 6'h3F);
endmodule // dpcmd_core_chk
bind dpcmd_core dpcmd_core_chk #(.NV_WRITE_CYC(NV_WRITE_CYC))
    i_dpcmd_core_chk (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .wiper_position_out(wiper_position_out),
    .tap_select_out(tap_select_out),
    .nv_busy_out(nv_busy_out)
);

// [dpcmd_master.sv]
// two-wire bus master model: clock and open-drain data, 1 = released
// assumes the bench resolves the data wire with a pull-up into sda_in
`timescale 1ns/1ps
module dpcmd_master (
    input wire logic ref_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // eight clocks a phase keeps well above the five the sampler needs
    task automatic phase();
        repeat (8) @(negedge ref_clk_in);
    endtask
    task automatic start();
        sda_out = 1'b1;
        phase();
        scl_out = 1'b1;
        phase();
        sda_out = 1'b0;
        phase();
        scl_out = 1'b0;
        phase();
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_out = b;
        phase();
        scl_out = 1'b1;
        phase();
        r = sda_in;
        scl_out = 1'b0;
        phase();
    endtask
    task automatic xbyte(input logic [7:0] tx, input logic ack_drv,
                         output logic [7:0] rx, output logic ack_seen);
        for (int i = 7; i >= 0; i--)
            xbit(tx[i], rx[i]);
        xbit(ack_drv, ack_seen);
    endtask
    // data low before the clock rises, so a stop also steps down once
    task automatic stop();
        sda_out = 1'b0;
        phase();
        scl_out = 1'b1;
        phase();
        sda_out = 1'b1;
        phase();
    endtask
endmodule // dpcmd_master

// [test_digipot_two_wire_command_frames.sv]
// self-checking bench for the potentiometer command interpreter
// assumes dpcmd_master as the bus master and the bound checker
`timescale 1ns/1ps
`include "dpcmd_defines.svh"
module test_digipot_two_wire_command_frames;
    localparam int NV_CYC = 20;
    // arbitrary type identifier, matched to the core's parameter
    localparam logic [3:0] TYPE_ID = 4'h6;
    localparam logic [7:0] BAD[3] = '{8'h80, 8'h02, 8'h08};
    logic ref_clk, rst_in, m_scl, m_sda, dut_sda, dut_oe, busy;
    logic [2:0] strap;
    logic [5:0] wiper;
    logic [63:0] taps;
    logic [7:0] addr_b, obs_v;
    logic [7:0] exp_q[$];
    dpcmd_pkg::dpcmd_bus_s bus;
    int seed = 32'h3671;
    int errors, comparisons, cyc;
    event obs_ev;
    assign addr_b = {TYPE_ID, strap[2:1], 1'b0, strap[0]};
    assign bus = {m_scl, m_sda & (dut_oe ? dut_sda : 1'b1)};
    dpcmd_master i_dpcmd_master (
        .ref_clk_in(ref_clk),
        .sda_in(bus.sda),
        .scl_out(m_scl),
        .sda_out(m_sda)
    );
    dpcmd_core #(.NV_WRITE_CYC(NV_CYC), .TYPE_ID(TYPE_ID)) i_dpcmd_core (
        .ref_clk_in(ref_clk),
        .rst_in(rst_in),
        .scl_in(bus.scl),
        .sda_in(bus.sda),
        .sda_out(dut_sda),
        .sda_oe_out(dut_oe),
        .addr_strap_high_in(strap[2]),
        .addr_strap_mid_in(strap[1]),
        .addr_strap_low_in(strap[0]),
        .wiper_position_out(wiper),
        .tap_select_out(taps),
        .nv_busy_out(busy)
    );
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic summarize();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic note(input logic [7:0] e, input logic [7:0] v);
        exp_q.push_back(e);
        obs_v = v;
        -> obs_ev;
        @(negedge ref_clk);
    endtask
    initial begin
        forever begin
            @(obs_ev);
            check(obs_v, exp_q.pop_front());
        end
    end
    // kind: 0 no data, 1 data byte, 2 read byte, 3 step bits
    task automatic frame(input logic [7:0] ad, input logic [7:0] ins,
                         input logic [7:0] d, input int kind,
                         output logic [7:0] rb);
        logic a;
        logic nak;
        nak = (ad !== addr_b);
        i_dpcmd_master.start();
        i_dpcmd_master.xbyte(ad, 1'b1, rb, a);
        note({7'h0, nak}, {7'h0, a});
        i_dpcmd_master.xbyte(ins, 1'b1, rb, a);
        note({7'h0, nak}, {7'h0, a});
        if (kind == 1) begin
            i_dpcmd_master.xbyte(d, 1'b1, rb, a);
            note({7'h0, nak}, {7'h0, a});
        end
        if (kind == 2)
            i_dpcmd_master.xbyte(8'hFF, 1'b0, rb, a);
        if (kind == 3)
            for (int i = 7; i >= 0; i--)
                i_dpcmd_master.xbit(d[i], a);
        i_dpcmd_master.stop();
    endtask
    task automatic wait_nv();
        int n;
        n = 0;
        note(8'h01, {7'h0, busy});
        while (busy !== 1'b0 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        note(8'h00, {7'h0, busy});
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        logic [7:0] rb;
        logic [5:0] v;
        logic [5:0] st[4];
        rst_in = 1'b1;
        strap = 3'h0;
        repeat (12) @(negedge ref_clk);
        strap = 3'($random(seed));
        rst_in = 1'b0;
        repeat (4) @(negedge ref_clk);
        note(8'h20, {2'h0, wiper});
        v = 6'($random(seed));
        frame(addr_b, {`DPCMD_OP_WR_WIPER, 4'h0}, {2'h0, v}, 1, rb);
        note({2'h0, v}, {2'h0, wiper});
        note(8'h01, {7'h0, taps == (64'h1 << v)});
        frame(addr_b, {`DPCMD_OP_RD_WIPER, 4'h0}, 8'h00, 2, rb);
        note({2'h0, v}, rb);
        $display("test wiper access done");
        for (int s = 0; s < 4; s++) begin
            st[s] = 6'($random(seed));
            frame(addr_b, {`DPCMD_OP_WR_STORE, 2'(s), 2'h0}, {2'h0, st[s]},
                  1, rb);
            wait_nv();
            frame(addr_b, {`DPCMD_OP_RD_STORE, 2'(s), 2'h0}, 8'h00, 2, rb);
            note({2'h0, st[s]}, rb);
        end
        $display("test store access done");
        frame(addr_b, {`DPCMD_OP_XFR_TO_STORE, 4'h8}, 8'h00, 0, rb);
        wait_nv();
        frame(addr_b, {`DPCMD_OP_XFR_TO_WIPER, 4'h4}, 8'h00, 0, rb);
        note({2'h0, st[1]}, {2'h0, wiper});
        frame(addr_b, {`DPCMD_OP_RD_STORE, 4'h8}, 8'h00, 2, rb);
        note({2'h0, v}, rb);
        $display("test transfers done");
        // up into the top end, down, up, and the stop adds one step down
        frame(addr_b, {`DPCMD_OP_WR_WIPER, 4'h0}, 8'h3E, 1, rb);
        frame(addr_b, {`DPCMD_OP_STEP, 4'h0}, 8'hE3, 3, rb);
        note(8'h3D, {2'h0, wiper});
        $display("test step mode done");
        for (int k = 0; k < 3; k++) begin
            frame(addr_b ^ BAD[k], {`DPCMD_OP_WR_WIPER, 4'h0}, 8'h05, 1, rb);
            note(8'h3D, {2'h0, wiper});
        end
        rst_in = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst_in = 1'b0;
        repeat (4) @(negedge ref_clk);
        note(8'h20, {2'h0, wiper});
        $display("test address and reset done");
        summarize();
    end
endmodule // test_digipot_two_wire_command_frames
